/* core/sam_matrix.sv */
// Behaviour
// R1: 0x0000_0000..0x0007_ffff goes to the flash slave.
// R2: 0x0300_0000..0x0300_ffff goes to the boot ROM slave.
// R3: 0x0400_0000..0x0400_7fff selects the instruction/data SRAM bank.
// R4: 0x1000_0000..0x17ff_ffff goes to the quad serial flash window.
// R5: 0x2000_0000..0x2002_7fff maps onto main SRAM banks.
// R6: 0x2200_0000..0x23ff_ffff is the SRAM bit-band alias, not unmapped.
// R7: 0x4000_0000..0x4001_ffff selects APB group 0.
// R8: 0x4002_0000..0x4003_ffff selects APB group 1.
// R9: 0x4004_0000..0x4005_ffff selects APB group 2 behind an async bridge.
// R10: 0x4008_0000..0x400b_ffff goes to the AHB peripheral slaves.
// R11: 0x4200_0000..0x43ff_ffff is the peripheral bit-band alias.
// R12: APB slot index is address bits above the 4 kB boundary.
// R13: Masters on different slave ports proceed together; same port arbitrates.
// R14: Instruction and data buses are separate masters running concurrently.
// R15: Core private registers are not decoded by this matrix.
// R16: Decode uses one flat 32-bit address space shared by all masters.
// R17: Unmapped addresses complete with an AHB-Lite error response.
`timescale 1ns/10ps
`default_nettype none
module sam_matrix #(
    parameter int NM = 3
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [NM-1:0][sam_pkg::SAM_AW-1:0] mst_haddr_i,
    input wire logic [NM-1:0][1:0] mst_htrans_i,
    input wire logic [NM-1:0] mst_hwrite_i,
    input wire logic [NM-1:0][2:0] mst_hsize_i,
    input wire logic [NM-1:0][sam_pkg::SAM_DW-1:0] mst_hwdata_i,
    output logic [NM-1:0][sam_pkg::SAM_DW-1:0] mst_hrdata_o,
    output logic [NM-1:0] mst_hready_o,
    output logic [NM-1:0] mst_hresp_o,
    output logic [sam_pkg::SAM_NS-1:0] slv_hsel_o,
    output logic [sam_pkg::SAM_NS-1:0][sam_pkg::SAM_AW-1:0] slv_haddr_o,
    output logic [sam_pkg::SAM_NS-1:0][1:0] slv_htrans_o,
    output logic [sam_pkg::SAM_NS-1:0] slv_hwrite_o,
    output logic [sam_pkg::SAM_NS-1:0][2:0] slv_hsize_o,
    output logic [sam_pkg::SAM_NS-1:0][sam_pkg::SAM_DW-1:0] slv_hwdata_o,
    output logic [sam_pkg::SAM_NS-1:0] slv_hready_o,
    input wire logic [sam_pkg::SAM_NS-1:0][sam_pkg::SAM_DW-1:0] slv_hrdata_i,
    input wire logic [sam_pkg::SAM_NS-1:0] slv_hreadyout_i,
    input wire logic [sam_pkg::SAM_NS-1:0] slv_hresp_i,
    output logic [sam_pkg::SAM_NAPB-1:0][sam_pkg::SAM_SLOT_W-1:0] apb_slot_o
);
    import sam_pkg::*;

    localparam int MW = (NM > 1) ? $clog2(NM) : 1;

    // Whole matrix state: per-master input stage and per-slave data-phase owner
    typedef struct packed {
        logic [NM-1:0] pend;
        logic [NM-1:0] dact;
        logic [NM-1:0] err1;
        logic [NM-1:0] err2;
        logic [NM-1:0][SAM_AW-1:0] addr;
        logic [NM-1:0] wr;
        logic [NM-1:0][2:0] size;
        logic [NM-1:0][1:0] trans;
        logic [NM-1:0][SAM_SW-1:0] sidx;
        logic [SAM_NS-1:0] dval;
        logic [SAM_NS-1:0][MW-1:0] down;
    } sam_state_t;

    sam_state_t r;
    sam_state_t next_r;
    logic [SAM_NS-1:0][MW:0] gnt;
    logic [NM-1:0] cap;
    logic [SAM_SW:0] dec0;

    // Fixed priority, lowest master index wins; a busy master can starve
    // a higher index on the same port, traded for a tiny arbiter
    function automatic logic [MW:0] pick(input logic [NM-1:0] p,
                                          input logic [NM-1:0][SAM_SW-1:0] si,
                                          input int s);
        logic [MW:0] g;
        g = '0;
        for (int m = NM - 1; m >= 0; m--) begin
            if (p[m] && si[m] == SAM_SW'(s)) begin
                g = {1'b1, MW'(m)};
            end
        end
        return g;
    endfunction : pick

    // Slave side: one transfer per port at a time, address only while idle
    for (genvar s = 0; s < SAM_NS; s++) begin : g_slv
        // R13: per-port arbiter
        assign gnt[s] = r.dval[s] ? '0 : pick(r.pend, r.sidx, s);
        assign slv_hsel_o[s] = gnt[s][MW];
        assign slv_haddr_o[s] = gnt[s][MW] ? r.addr[gnt[s][MW-1:0]] : '0;
        assign slv_htrans_o[s] = gnt[s][MW] ? r.trans[gnt[s][MW-1:0]] : SAM_TR_IDLE;
        assign slv_hwrite_o[s] = gnt[s][MW] ? r.wr[gnt[s][MW-1:0]] : 1'b0;
        assign slv_hsize_o[s] = gnt[s][MW] ? r.size[gnt[s][MW-1:0]] : 3'h0;
        assign slv_hwdata_o[s] = r.dval[s] ? mst_hwdata_i[r.down[s]] : '0;
        assign slv_hready_o[s] = r.dval[s] ? slv_hreadyout_i[s] : 1'b1;
    end

    // R12: slot index taken straight from the routed address
    for (genvar g = 0; g < SAM_NAPB; g++) begin : g_slot
        assign apb_slot_o[g] = slv_haddr_o[SAM_APB0 + g][SAM_SLOT_LSB +: SAM_SLOT_W];
    end

    // Master side: stalled while the captured address waits or the slave works
    for (genvar m = 0; m < NM; m++) begin : g_mst
        assign mst_hready_o[m] = r.pend[m] ? 1'b0 :
                                 r.dact[m] ? slv_hreadyout_i[r.sidx[m]] : !r.err1[m];
        assign mst_hresp_o[m] = r.dact[m] ? slv_hresp_i[r.sidx[m]] : (r.err1[m] | r.err2[m]);
        assign mst_hrdata_o[m] = r.dact[m] ? slv_hrdata_i[r.sidx[m]] : '0;
        assign cap[m] = mst_hready_o[m] && mst_htrans_i[m][1];
    end

    // Next state: completions first, then issues, then new captures
    always_comb begin
        logic [SAM_SW:0] dec;
        dec = '0;
        next_r = r;
        for (int s = 0; s < SAM_NS; s++) begin
            if (r.dval[s] && slv_hreadyout_i[s]) begin
                next_r.dval[s] = 1'b0;
            end
        end
        for (int m = 0; m < NM; m++) begin
            if (r.dact[m] && slv_hreadyout_i[r.sidx[m]]) begin
                next_r.dact[m] = 1'b0;
            end
            next_r.err2[m] = r.err1[m]; // Second error cycle raises ready
            next_r.err1[m] = 1'b0;
        end
        // R13: independent ports issue in the same cycle
        for (int s = 0; s < SAM_NS; s++) begin
            if (gnt[s][MW]) begin
                next_r.dval[s] = 1'b1;
                next_r.down[s] = gnt[s][MW-1:0];
                next_r.pend[gnt[s][MW-1:0]] = 1'b0;
                next_r.dact[gnt[s][MW-1:0]] = 1'b1;
            end
        end
        // R14: every master owns its own input stage
        for (int m = 0; m < NM; m++) begin
            if (cap[m]) begin
                // R16: full-width flat decode
                dec = sam_decode(mst_haddr_i[m]);
                if (dec[SAM_SW]) begin
                    next_r.pend[m] = 1'b1;
                    next_r.sidx[m] = dec[SAM_SW-1:0];
                    next_r.addr[m] = mst_haddr_i[m];
                    next_r.wr[m] = mst_hwrite_i[m];
                    next_r.size[m] = mst_hsize_i[m];
                    next_r.trans[m] = SAM_TR_NONSEQ;
                end else begin
                    // R17: two-cycle error for unmapped space
                    // R15: private bus space falls here too
                    next_r.err1[m] = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // R1: flash decode
    flash_route_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
        (cap[0] && mst_haddr_i[0] <= 32'h0007_ffff) |=> (r.pend[0] && r.sidx[0] == SAM_FLASH))
        else $error("flash address not routed to flash");

    // R2: boot ROM decode
    boot_route_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
        (cap[1] && mst_haddr_i[1][31:16] == 16'h0300) |=> (r.pend[1] && r.sidx[1] == SAM_BOOT_ROM))
        else $error("boot ROM address misrouted");

    // R3: I&D bank decode
    idbank_route_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
        (cap[0] && mst_haddr_i[0][31:15] == 17'h0800)
        |=> (r.pend[0] && r.sidx[0] == SAM_INSTR_DATA_SRAM_BANK))
        else $error("instruction/data bank misrouted");

    // R4: serial flash window decode
    qsf_route_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R4
        (cap[0] && mst_haddr_i[0][31:27] == 5'h02)
        |=> (r.pend[0] && r.sidx[0] == SAM_QUAD_SERIAL_FLASH_WINDOW))
        else $error("serial flash window misrouted");

    // R5: main SRAM decode
    sram_route_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
        (cap[1] && mst_haddr_i[1] >= 32'h2000_0000 && mst_haddr_i[1] <= 32'h2002_7fff)
        |=> (r.pend[1] && r.sidx[1] == SAM_SRAM))
        else $error("main SRAM misrouted");

    // R6: SRAM alias decode
    sram_alias_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
        (cap[0] && mst_haddr_i[0][31:25] == 7'h11)
        |=> (r.pend[0] && !r.err1[0] && r.sidx[0] == SAM_SRAM_BITBAND))
        else $error("SRAM bit-band alias misrouted");

    // R7: APB group 0 decode
    apb0_route_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
        (cap[0] && mst_haddr_i[0][31:17] == 15'h2000) |=> (r.sidx[0] == SAM_APB0))
        else $error("APB group 0 misrouted");

    // R8: APB group 1 decode
    apb1_route_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R8
        (cap[1] && mst_haddr_i[1][31:17] == 15'h2001) |=> (r.sidx[1] == SAM_APB1))
        else $error("APB group 1 misrouted");

    // R9: APB group 2 decode and a held bridge stall
    apb2_route_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
        (cap[0] && mst_haddr_i[0][31:17] == 15'h2002) |=> (r.sidx[0] == SAM_APB2))
        else $error("APB group 2 misrouted");
    apb2_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
        (r.dval[SAM_APB2] && !slv_hreadyout_i[SAM_APB2])
        |=> (r.dval[SAM_APB2] && $stable(r.down[SAM_APB2])))
        else $error("bridge wait dropped owner");

    // R10: AHB peripheral decode
    ahbp_route_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R10
        (cap[0] && mst_haddr_i[0][31:18] == 14'h1002) |=> (r.sidx[0] == SAM_AHB_PERIPH))
        else $error("AHB peripheral misrouted");

    // R11: peripheral alias decode
    palias_route_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
        (cap[1] && mst_haddr_i[1][31:25] == 7'h21)
        |=> (r.pend[1] && r.sidx[1] == SAM_PERIPH_BITBAND))
        else $error("peripheral bit-band alias misrouted");

    // R12: slot index on issue
    apb_slot_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R12
        (r.pend[0] && r.sidx[0] == SAM_APB2 && !r.dval[SAM_APB2])
        |-> (slv_hsel_o[SAM_APB2] && apb_slot_o[2] == r.addr[0][16:12]))
        else $error("APB slot index wrong");

    // R13: two ports served at once
    par_issue_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
        (r.pend[0] && r.pend[1] && r.sidx[0] != r.sidx[1]
         && !r.dval[r.sidx[0]] && !r.dval[r.sidx[1]])
        |=> (r.dact[0] && r.dact[1]))
        else $error("independent ports not concurrent");

    // R13: same port grants one owner
    one_owner_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
        (r.pend[0] && r.pend[1] && r.sidx[0] == r.sidx[1] && !r.dval[r.sidx[0]])
        |=> (r.dact[0] && r.pend[1]))
        else $error("same-port arbitration wrong");

    // R14: data bus not blocked by fetch elsewhere
    data_free_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R14
        (r.pend[1] && !r.dval[r.sidx[1]] && (!r.pend[0] || r.sidx[0] != r.sidx[1]))
        |=> r.dact[1])
        else $error("data bus blocked by fetch");

    // R15: private bus space errors
    ppb_err_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
        (cap[1] && mst_haddr_i[1][31:28] == 4'he) |=> (r.err1[1] && !r.pend[1]))
        else $error("private bus space decoded");

    // R16: no aliasing anywhere in the upper half
    flat_map_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R16
        (cap[1] && mst_haddr_i[1][31]) |=> r.err1[1])
        else $error("high address aliased");

    // Decode of master 0 held apart, a function result cannot be bit-selected
    assign dec0 = sam_decode(mst_haddr_i[0]);

    // R17: two-cycle error response
    err_resp_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R17
        (cap[0] && !dec0[SAM_SW])
        |=> (!mst_hready_o[0] && mst_hresp_o[0]) ##1 (mst_hready_o[0] && mst_hresp_o[0]))
        else $error("unmapped access not errored");

    // R9: bridge stall reaches the owning master
    apb2_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
        (r.dval[SAM_APB2] && !slv_hreadyout_i[SAM_APB2]) |-> !mst_hready_o[r.down[SAM_APB2]])
        else $error("bridge stall not passed back");

    // R12: group 0 slot follows the routed address
    apb0_slot_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R12
        slv_hsel_o[SAM_APB0] |-> (apb_slot_o[0] == r.addr[r.down[SAM_APB0]][16:12] || r.dval[SAM_APB0]
        || apb_slot_o[0] == slv_haddr_o[SAM_APB0][16:12]))
        else $error("APB group 0 slot wrong");

    // Per-port checks: a port never shows two transfers at once
    for (genvar s = 0; s < SAM_NS; s++) begin : g_port_chk
        // R13: address phase lasts one cycle
        hsel_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
            slv_hsel_o[s] |=> !slv_hsel_o[s])
            else $error("slave select held too long");

        // R16: a port only sees its own region
        sel_range_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R16
            slv_hsel_o[s] |-> (slv_haddr_o[s] >= SAM_BASE[s] && slv_haddr_o[s] <= SAM_LIMIT[s]))
            else $error("address outside port region");

        // R13: data phase owner is waiting on this port
        owner_ok_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
            r.dval[s] |-> (r.dact[r.down[s]] && r.sidx[r.down[s]] == SAM_SW'(s)))
            else $error("port owner inconsistent");

        // R13: no new address while data phase runs
        no_reissue_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
            r.dval[s] |-> !slv_hsel_o[s])
            else $error("port reissued during data phase");

        // R13: unselected port shows an idle transfer
        idle_bus_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
            !slv_hsel_o[s] |-> (slv_htrans_o[s] == SAM_TR_IDLE))
            else $error("unselected port not idle");
    end

    // Per-master checks on the answer side
    for (genvar m = 0; m < NM; m++) begin : g_mst_chk
        // R14: captured address stalls its own master only
        pend_stall_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R14
            r.pend[m] |-> !mst_hready_o[m])
            else $error("pending master not stalled");

        // R17: first error cycle holds ready low
        err_first_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R17
            r.err1[m] |-> (!mst_hready_o[m] && mst_hresp_o[m]))
            else $error("first error cycle wrong");

        // R17: second error cycle raises ready
        err_tail_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R17
            r.err2[m] |-> (mst_hready_o[m] && mst_hresp_o[m]))
            else $error("second error cycle wrong");

        // R17: an idle master sees a zero-wait okay
        idle_okay_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R17
            (!r.pend[m] && !r.dact[m] && !r.err1[m] && !r.err2[m]) |-> (mst_hready_o[m] && !mst_hresp_o[m]))
            else $error("idle master not okay");
    end
endmodule : sam_matrix
`default_nettype wire

/* pkg/sam_pkg.sv */
`default_nettype none
package sam_pkg;
    // Bus widths of the flat address space
    localparam int SAM_AW = 32;
    localparam int SAM_DW = 32;
    // Slave ports of the matrix, in decode order
    localparam int SAM_NS = 11;
    localparam int SAM_SW = 4;
    localparam int SAM_FLASH = 0;
    localparam int SAM_BOOT_ROM = 1;
    localparam int SAM_INSTR_DATA_SRAM_BANK = 2;
    localparam int SAM_QUAD_SERIAL_FLASH_WINDOW = 3;
    localparam int SAM_SRAM = 4;
    localparam int SAM_SRAM_BITBAND = 5;
    localparam int SAM_APB0 = 6;
    localparam int SAM_APB1 = 7;
    localparam int SAM_APB2 = 8;
    localparam int SAM_AHB_PERIPH = 9;
    localparam int SAM_PERIPH_BITBAND = 10;
    // APB groups share one slot layout
    localparam int SAM_NAPB = 3;
    localparam int SAM_SLOT_LSB = 12;
    localparam int SAM_SLOT_W = 5;
    // Region bounds, inclusive
    localparam logic [31:0] SAM_BASE [SAM_NS] = '{
        32'h0000_0000, 32'h0300_0000, 32'h0400_0000, 32'h1000_0000,
        32'h2000_0000, 32'h2200_0000, 32'h4000_0000, 32'h4002_0000,
        32'h4004_0000, 32'h4008_0000, 32'h4200_0000};
    localparam logic [31:0] SAM_LIMIT [SAM_NS] = '{
        32'h0007_ffff, 32'h0300_ffff, 32'h0400_7fff, 32'h17ff_ffff,
        32'h2002_7fff, 32'h23ff_ffff, 32'h4001_ffff, 32'h4003_ffff,
        32'h4005_ffff, 32'h400b_ffff, 32'h43ff_ffff};
    // Transfer type codes
    localparam logic [1:0] SAM_TR_IDLE = 2'h0;
    localparam logic [1:0] SAM_TR_NONSEQ = 2'h2;

    // Returns {hit, slave index}; the whole 32-bit address takes part
    function automatic logic [SAM_SW:0] sam_decode(input logic [SAM_AW-1:0] a);
        logic [SAM_SW:0] d;
        d = '0;
        for (int s = 0; s < SAM_NS; s++) begin
            if (a >= SAM_BASE[s] && a <= SAM_LIMIT[s]) begin
                d = {1'b1, SAM_SW'(s)};
            end
        end
        return d;
    endfunction : sam_decode
endpackage : sam_pkg
`default_nettype wire

/* tb/sam_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Slave ports answer from the captured address; odd ports add one wait state
module sam_slave_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [sam_pkg::SAM_NS-1:0] hsel_i,
    input wire logic [sam_pkg::SAM_NS-1:0][sam_pkg::SAM_AW-1:0] haddr_i,
    input wire logic [sam_pkg::SAM_NS-1:0] hready_i,
    output logic [sam_pkg::SAM_NS-1:0][sam_pkg::SAM_DW-1:0] hrdata_o,
    output logic [sam_pkg::SAM_NS-1:0] hreadyout_o,
    output logic [sam_pkg::SAM_NS-1:0] hresp_o
);
    import sam_pkg::*;
    logic [SAM_NS-1:0] busy;
    logic [SAM_NS-1:0] wt;
    logic [SAM_NS-1:0][SAM_AW-1:0] addr;
    // Address phase capture, then data phase held for the wait count
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            busy <= '0;
            wt <= '0;
            addr <= '0;
        end else begin
            for (int s = 0; s < SAM_NS; s++) begin
                if (hsel_i[s] && hready_i[s]) begin
                    busy[s] <= 1'b1;
                    wt[s] <= s[0];
                    addr[s] <= haddr_i[s];
                end else if (wt[s]) begin
                    wt[s] <= 1'b0;
                end else begin
                    busy[s] <= 1'b0;
                end
            end
        end
    end
    // Outside the answer the data toggles, so a stale value never matches
    always_comb begin
        for (int s = 0; s < SAM_NS; s++) begin
            hreadyout_o[s] = !wt[s];
            hrdata_o[s] = (busy[s] && !wt[s]) ? {4'(s), addr[s][27:0]} : ~addr[s] ^ {32{mclk_i}};
        end
    end
    assign hresp_o = '0; // Mapped slaves always say OKAY
endmodule : sam_slave_model
`default_nettype wire

/* tb/system_address_map_decoder_test.sv */
`timescale 1ns/10ps
`default_nettype none
module system_address_map_decoder_test;
    import sam_pkg::*;
    localparam logic [31:0] base [11] = '{32'h0000_0000, 32'h0300_0000, 32'h0400_0000, 32'h1000_0000,
        32'h2000_0000, 32'h2200_0000, 32'h4000_0000, 32'h4002_0000, 32'h4004_0000, 32'h4008_0000, 32'h4200_0000};
    localparam logic [31:0] lim [11] = '{32'h0007_ffff, 32'h0300_ffff, 32'h0400_7fff, 32'h17ff_ffff,
        32'h2002_7fff, 32'h23ff_ffff, 32'h4001_ffff, 32'h4003_ffff, 32'h4005_ffff, 32'h400b_ffff, 32'h43ff_ffff};
    localparam logic [31:0] hole [9] = '{32'h0008_0000, 32'h02ff_ffff, 32'h0400_8000, 32'h1800_0000,
        32'h2002_8000, 32'h4006_0000, 32'h4400_0000, 32'he000_e010, 32'hffff_ffff};
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0][31:0] haddr = '0;
    logic [2:0][31:0] hwdata = '0;
    logic [2:0][1:0] htrans = '0;
    logic [2:0] hwrite = '0;
    logic [2:0][31:0] hrdata;
    logic [2:0] hready, hresp;
    logic [10:0] hsel, shready, shreadyout, shresp;
    logic [10:0][31:0] shaddr, shwdata, shrdata;
    logic [2:0][4:0] slot;
    int n_errors = 0, checked = 0, sel_cnt = 0, last_sel = 0;
    int n [3];
    logic [2:0][31:0] rd;
    logic [2:0] rs;
    logic [31:0] addr_seen, wd_seen;
    logic [4:0] slot_seen;
    always #12.5 mclk_i = ~mclk_i;
    sam_matrix i_sam_matrix (.mclk_i(mclk_i), .rst_i(rst_i), .mst_haddr_i(haddr), .mst_htrans_i(htrans),
        .mst_hwrite_i(hwrite), .mst_hsize_i({3{3'h2}}), .mst_hwdata_i(hwdata), .mst_hrdata_o(hrdata),
        .mst_hready_o(hready), .mst_hresp_o(hresp), .slv_hsel_o(hsel), .slv_haddr_o(shaddr), .slv_htrans_o(),
        .slv_hwrite_o(), .slv_hsize_o(), .slv_hwdata_o(shwdata), .slv_hready_o(shready),
        .slv_hrdata_i(shrdata), .slv_hreadyout_i(shreadyout), .slv_hresp_i(shresp), .apb_slot_o(slot));
    sam_slave_model i_sam_slave_model (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(shaddr),
        .hready_i(shready), .hrdata_o(shrdata), .hreadyout_o(shreadyout), .hresp_o(shresp));
    // Slave address phases seen on the matrix side
    always @(posedge mclk_i) begin
        for (int s = 0; s < 11; s++) begin
            if (hsel[s] === 1'b1) begin
                sel_cnt++;
                last_sel = s;
                addr_seen = shaddr[s];
                if (s >= 6 && s <= 8) slot_seen = slot[s-6];
            end
        end
    end
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Masters in en issue together; idle masters are taken at the next edge
    task automatic issue(input logic [2:0] en, input logic [2:0][31:0] a, input logic w);
        @(posedge mclk_i);
        for (int m = 0; m < 3; m++) begin
            n[m] = 0;
            if (en[m]) begin
                haddr[m] <= a[m];
                htrans[m] <= SAM_TR_NONSEQ;
                hwrite[m] <= w;
            end
        end
        @(posedge mclk_i);
        for (int m = 0; m < 3; m++) begin
            if (en[m]) begin
                htrans[m] <= SAM_TR_IDLE;
                hwdata[m] <= a[m] ^ 32'h5a5a_5a5a;
            end
        end
        for (int i = 1; i <= 40; i++) begin
            @(negedge mclk_i);
            for (int m = 0; m < 3; m++) begin
                if (en[m] && n[m] == 0 && hready[m] === 1'b1) begin
                    n[m] = i;
                    rd[m] = hrdata[m];
                    rs[m] = hresp[m];
                    if (last_sel < 11) wd_seen = shwdata[last_sel];
                end
            end
        end
        for (int m = 0; m < 3; m++) begin
            if (en[m] && n[m] == 0) begin
                n_errors++;
                finish_test();
            end
        end
    endtask : issue
    // region edges routed, masters 0 and 1 in turn
    task automatic t_map();
        logic [31:0] a;
        int s, m, c0;
        for (int i = 0; i < 22; i++) begin
            s = i / 2;
            m = i % 2;
            a = i[0] ? lim[s] : base[s];
            c0 = sel_cnt;
            issue(3'(1 << m), {3{a}}, i[1]);
            check(32'(sel_cnt - c0), 1);
            check(32'(last_sel), 32'(s));
            check(addr_seen, a);
            check(rs[m], 0);
            if (i[1]) check(wd_seen, a ^ 32'h5a5a_5a5a);
            else check(rd[m], {s[3:0], a[27:0]});
        end
    endtask : t_map
    // gaps and private bus answer ERROR without a slave
    task automatic t_hole();
        int c0;
        for (int i = 0; i < 9; i++) begin
            c0 = sel_cnt;
            issue(3'(1 << (i % 3)), {3{hole[i]}}, i[0]);
            check(rs[i%3], 1);
            check(32'(n[i%3]), 2);
            check(32'(sel_cnt - c0), 0);
        end
    endtask : t_hole
    // slot index from bits above 4 kB
    task automatic t_slot();
        logic [4:0] sl;
        for (int i = 0; i < 9; i++) begin
            sl = (i % 3 == 0) ? 5'h00 : (i % 3 == 1) ? 5'h1f : 5'h0a;
            issue(3'(1 << ((i + i / 3) % 3)), {3{32'h4000_0000 + 32'(i / 3) * 32'h2_0000 + {15'h0, sl, 12'hffc}}},
                1'b0);
            check(slot_seen, sl);
        end
    endtask : t_slot
    // parallel ports finish together, shared port arbitrates
    task automatic t_para();
        issue(3'h3, {32'h0, 32'h2000_0100, 32'h0000_0100}, 1'b0);
        check(32'(n[0]), 2);
        check(32'(n[1]), 2);
        check(rd[1], 32'h4000_0100);
        issue(3'h6, {32'h0400_0010, 32'h0400_0020, 32'h0}, 1'b0);
        check(32'(n[1]), 2);
        check(n[2] > 2, 1);
        check(rd[2], 32'h2400_0010);
        issue(3'h3, {32'h0, 32'h0400_0020, 32'h0400_0010}, 1'b0);
        check(32'(n[0]), 2);
        check(n[1] > 2, 1);
        check(rd[1], 32'h2400_0020);
    endtask : t_para
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_map();
        t_hole();
        t_slot();
        t_para();
        finish_test();
    end
endmodule : system_address_map_decoder_test
`default_nettype wire
